/* File: rtl/sfa_defs.vh */
// Shared constants for the servo fault alarm encoder.
`ifndef SFA_DEFS_VH
`define SFA_DEFS_VH

// Alarm codes reported on the alarm code output.
`define SFA_CODE_W          6
`define SFA_CODE_NONE       6'h00
`define SFA_CODE_OVERSPEED  6'h01
`define SFA_CODE_OVERTRAVEL 6'h04
`define SFA_CODE_SPD_SAT    6'h06
`define SFA_CODE_INHIBIT    6'h07
`define SFA_CODE_DEV_RANGE  6'h08
`define SFA_CODE_DISCONN    6'h0a
`define SFA_CODE_BRAKE_DLY  6'h13
`define SFA_CODE_LOGIC_ERR  6'h15
`define SFA_CODE_TRQ_OVL    6'h1d
`define SFA_CODE_ENC_CODE   6'h20
`define SFA_CODE_ENC_HIZ    6'h21
`define SFA_CODE_ENC_ILLEG  6'h24
`define SFA_CODE_CRC        6'h37
`define SFA_CODE_FRAME_LEN  6'h38
`define SFA_CODE_LOOP_TMO   6'h3c

// Accumulated deviation limit exponent: magnitude above 2**30 pulses.
`define SFA_DEV_RANGE_EXP   30

// Consecutive CRC failures that raise the CRC alarm.
`define SFA_CRC_FAIL_LIMIT  2'h3

// Clock rate and time constants, in their own units.
`define SFA_CLK_HZ          10000000
`define SFA_SAT_TIME_MS     1000
`define SFA_ILLEG_TIME_MS   1000
`define SFA_LOOP_TMO_US     100

`endif

/* File: rtl/sfa_persist.v */
// Persistence filter: a condition must hold for a number of cycles to fire.
module sfa_persist #(
	parameter CNT_W = 24
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire             i_cond,
	input  wire [CNT_W-1:0] i_limit,
	output reg              o_fire
);

	reg [CNT_W-1:0] cnt_q;

	// Counts while the condition stands; any break restarts the wait.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q  <= {CNT_W{1'b0}};
			o_fire <= 1'b0;
		end else if (!i_cond) begin
			cnt_q  <= {CNT_W{1'b0}};
			o_fire <= 1'b0;
		end else if (cnt_q >= i_limit) begin
			o_fire <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			o_fire <= 1'b0;
		end
	end

endmodule // sfa_persist

/* File: rtl/sfa_fault_encoder.v */
// Servo drive fault monitor that encodes the detected fault as an alarm code.
`include "sfa_defs.vh"

module sfa_fault_encoder #(
	parameter SPD_W        = 16,
	parameter DEV_W        = 32,
	parameter ACC_W        = 40,
	parameter DLY_W        = 16,
	parameter TRQ_W        = 16,
	parameter CNT_W        = 24,
	parameter SAT_CYCLES   = (`SFA_CLK_HZ / 1000) * `SFA_SAT_TIME_MS,
	parameter ILLEG_CYCLES = (`SFA_CLK_HZ / 1000) * `SFA_ILLEG_TIME_MS,
	parameter TMO_CYCLES   = (`SFA_CLK_HZ / 1000000) * `SFA_LOOP_TMO_US
) (
	input  wire             i_clk,
	input  wire             i_rst,
	input  wire [SPD_W-1:0] i_motor_speed,
	input  wire [SPD_W-1:0] i_speed_command,
	input  wire [SPD_W-1:0] i_overspeed_limit,
	input  wire [SPD_W-1:0] i_speed_tolerance,
	input  wire [DEV_W-1:0] i_deviation_count,
	input  wire [DEV_W-1:0] i_deviation_limit,
	input  wire [ACC_W-1:0] i_deviation_accum,
	input  wire             i_cw_inhibit_ok,
	input  wire             i_ccw_inhibit_ok,
	input  wire             i_inhibit_check_en,
	input  wire             i_phase_u_ok,
	input  wire             i_phase_v_ok,
	input  wire             i_phase_w_ok,
	input  wire             i_enc_u,
	input  wire             i_enc_v,
	input  wire             i_enc_w,
	input  wire             i_enc_mismatch,
	input  wire             i_enc_hiz_seen,
	input  wire             i_power_on_check,
	input  wire             i_nine_line_mode,
	input  wire             i_enc_illegal,
	input  wire             i_crc_done,
	input  wire             i_crc_fail,
	input  wire             i_frame_too_long,
	input  wire             i_loop_irq,
	input  wire [DLY_W-1:0] i_brake_release_delay_setting,
	input  wire [DLY_W-1:0] i_brake_delay_max,
	input  wire [TRQ_W-1:0] i_torque_overload_level_setting,
	input  wire [TRQ_W-1:0] i_torque_overload_time_setting,
	input  wire [TRQ_W-1:0] i_torque_level_max,
	input  wire             i_sudden_load,
	input  wire             i_logic_module_err,
	input  wire             i_alarm_reset,
	output reg  [`SFA_CODE_W-1:0] o_alarm_code,
	output reg              o_fault_indicator_output
);

	// Pin-level inputs pass two flip-flops before any logic sees them.
	localparam PIN_N = 14;
	wire [PIN_N-1:0] pin_raw;
	reg  [PIN_N-1:0] pin_meta_q;
	reg  [PIN_N-1:0] pin_q;

	assign pin_raw = {i_cw_inhibit_ok, i_ccw_inhibit_ok, i_phase_u_ok, i_phase_v_ok,
		i_phase_w_ok, i_enc_u, i_enc_v, i_enc_w, i_enc_hiz_seen, i_power_on_check,
		i_alarm_reset, i_sudden_load, i_nine_line_mode, i_inhibit_check_en};

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta_q <= {PIN_N{1'b0}};
			pin_q      <= {PIN_N{1'b0}};
		end else begin
			pin_meta_q <= pin_raw;
			pin_q      <= pin_meta_q;
		end
	end

	wire s_cw_ok     = pin_q[13];
	wire s_ccw_ok    = pin_q[12];
	wire s_ph_u      = pin_q[11];
	wire s_ph_v      = pin_q[10];
	wire s_ph_w      = pin_q[9];
	wire s_enc_u     = pin_q[8];
	wire s_enc_v     = pin_q[7];
	wire s_enc_w     = pin_q[6];
	wire s_hiz_seen  = pin_q[5];
	wire s_pon_check = pin_q[4];
	wire s_arst      = pin_q[3];
	wire s_sudden    = pin_q[2];
	wire s_nine      = pin_q[1];
	wire s_inh_en    = pin_q[0];

	// Magnitude of a two's complement value, used for both deviation checks.
	function [ACC_W-1:0] sfa_abs;
		input [ACC_W-1:0] v;
		begin
			sfa_abs = v[ACC_W-1] ? (~v + {{(ACC_W-1){1'b0}}, 1'b1}) : v;
		end
	endfunction

	wire [ACC_W-1:0] dev_cnt_ext = {{(ACC_W-DEV_W){i_deviation_count[DEV_W-1]}}, i_deviation_count};
	wire [ACC_W-1:0] dev_lim_ext = {{(ACC_W-DEV_W){1'b0}}, i_deviation_limit};
	wire [ACC_W-1:0] dev_range   = {{(ACC_W-1){1'b0}}, 1'b1} << `SFA_DEV_RANGE_EXP;

	// Speed error magnitude for the saturation watch.
	wire [SPD_W-1:0] spd_err = (i_speed_command > i_motor_speed) ?
		(i_speed_command - i_motor_speed) : (i_motor_speed - i_speed_command);

	// Long-interval conditions go through persistence filters.
	wire sat_fire;
	wire illeg_fire;

	sfa_persist #(.CNT_W(CNT_W)) u_sat (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_cond  (spd_err > i_speed_tolerance),
		.i_limit (SAT_CYCLES[CNT_W-1:0]),
		.o_fire  (sat_fire)
	);

	sfa_persist #(.CNT_W(CNT_W)) u_illeg (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_cond  (s_nine & i_enc_illegal),
		.i_limit (ILLEG_CYCLES[CNT_W-1:0]),
		.o_fire  (illeg_fire)
	);

	// Consecutive CRC failure counter; a good check restarts the run.
	reg [1:0] crc_run_q;
	reg       crc_fire_q;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			crc_run_q  <= 2'h0;
			crc_fire_q <= 1'b0;
		end else if (i_crc_done) begin
			if (!i_crc_fail) begin
				crc_run_q  <= 2'h0;
				crc_fire_q <= 1'b0;
			end else if (crc_run_q + 2'h1 >= `SFA_CRC_FAIL_LIMIT) begin
				crc_run_q  <= `SFA_CRC_FAIL_LIMIT;
				crc_fire_q <= 1'b1;
			end else begin
				crc_run_q  <= crc_run_q + 2'h1;
			end
		end
	end

	// Current-loop interrupt watchdog; every interrupt restarts the wait.
	reg [CNT_W-1:0] tmo_cnt_q;
	reg             tmo_fire_q;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			tmo_cnt_q  <= {CNT_W{1'b0}};
			tmo_fire_q <= 1'b0;
		end else if (i_loop_irq) begin
			tmo_cnt_q  <= {CNT_W{1'b0}};
			tmo_fire_q <= 1'b0;
		end else if (tmo_cnt_q >= TMO_CYCLES[CNT_W-1:0]) begin
			tmo_fire_q <= 1'b1;
		end else begin
			tmo_cnt_q  <= tmo_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Power-on encoder check: the lines must have floated while the strobe stood.
	reg hiz_fire_q;

	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hiz_fire_q <= 1'b0;
		end else begin
			hiz_fire_q <= s_pon_check & ~s_hiz_seen;
		end
	end

	// Individual fault conditions.
	wire f_overspeed = i_motor_speed > i_overspeed_limit;
	wire f_travel    = sfa_abs(dev_cnt_ext) > dev_lim_ext;
	wire f_inhibit   = s_inh_en & ~(s_cw_ok & s_ccw_ok);
	wire f_range     = sfa_abs(i_deviation_accum) > dev_range;
	wire f_disconn   = ~(s_ph_u & s_ph_v & s_ph_w);
	wire f_enc_code  = (s_enc_u & s_enc_v & s_enc_w) |
		~(s_enc_u | s_enc_v | s_enc_w) | i_enc_mismatch;
	wire f_brake     = i_brake_release_delay_setting > i_brake_delay_max;
	wire f_trq       = (i_torque_overload_level_setting > i_torque_level_max) |
		(i_torque_overload_time_setting == {TRQ_W{1'b0}}) | s_sudden;

	// Priority encoder: lowest listed code wins when several appear together.
	reg [`SFA_CODE_W-1:0] code_d;

	always @* begin
		code_d = `SFA_CODE_NONE;
		if (f_overspeed)              code_d = `SFA_CODE_OVERSPEED;
		else if (f_travel)            code_d = `SFA_CODE_OVERTRAVEL;
		else if (sat_fire)            code_d = `SFA_CODE_SPD_SAT;
		else if (f_inhibit)           code_d = `SFA_CODE_INHIBIT;
		else if (f_range)             code_d = `SFA_CODE_DEV_RANGE;
		else if (f_disconn)           code_d = `SFA_CODE_DISCONN;
		else if (f_brake)             code_d = `SFA_CODE_BRAKE_DLY;
		else if (i_logic_module_err)  code_d = `SFA_CODE_LOGIC_ERR;
		else if (f_trq)               code_d = `SFA_CODE_TRQ_OVL;
		else if (f_enc_code)          code_d = `SFA_CODE_ENC_CODE;
		else if (hiz_fire_q)          code_d = `SFA_CODE_ENC_HIZ;
		else if (illeg_fire)          code_d = `SFA_CODE_ENC_ILLEG;
		else if (crc_fire_q)          code_d = `SFA_CODE_CRC;
		else if (i_frame_too_long)    code_d = `SFA_CODE_FRAME_LEN;
		else if (tmo_fire_q)          code_d = `SFA_CODE_LOOP_TMO;
	end

	// Latch the first code; clearing needs both the request and a quiet cause.
	// Holding the first fault keeps the root cause visible after a cascade.
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_alarm_code             <= `SFA_CODE_NONE;
			o_fault_indicator_output <= 1'b0;
		end else if (o_alarm_code == `SFA_CODE_NONE) begin
			o_alarm_code             <= code_d;
			o_fault_indicator_output <= (code_d == `SFA_CODE_NONE);
		end else if (s_arst && code_d == `SFA_CODE_NONE) begin
			o_alarm_code             <= `SFA_CODE_NONE;
			o_fault_indicator_output <= 1'b1;
		end else begin
			o_fault_indicator_output <= 1'b0;
		end
	end

endmodule // sfa_fault_encoder

/* File: sim/sfa_checker.sv */
// Port-level assertions for the servo fault alarm encoder.
`include "sfa_defs.vh"
module sfa_checker (
	input wire logic                   i_clk,
	input wire logic                   i_rst,
	input wire logic [15:0]            i_motor_speed,
	input wire logic [15:0]            i_overspeed_limit,
	input wire logic [31:0]            i_deviation_count,
	input wire logic [31:0]            i_deviation_limit,
	input wire logic [39:0]            i_deviation_accum,
	input wire logic                   i_enc_mismatch,
	input wire logic                   i_frame_too_long,
	input wire logic [15:0]            i_brake_release_delay_setting,
	input wire logic [15:0]            i_brake_delay_max,
	input wire logic                   i_logic_module_err,
	input wire logic                   i_alarm_reset,
	input wire logic [`SFA_CODE_W-1:0] o_alarm_code,
	input wire logic                   o_fault_indicator_output
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Decoded fault conditions; magnitudes follow the signed counters.
	wire        idle_c  = o_alarm_code == `SFA_CODE_NONE;
	wire        spd_f   = i_motor_speed > i_overspeed_limit;
	wire [31:0] dev_m   = i_deviation_count[31] ? -i_deviation_count : i_deviation_count;
	wire [39:0] acc_m   = i_deviation_accum[39] ? -i_deviation_accum : i_deviation_accum;
	wire        dev_f   = dev_m > i_deviation_limit;
	// The first edge after reset still sees reset values, so it is skipped.
	a_ind_tracks_code: assert property (!$past(i_rst) |-> o_fault_indicator_output == idle_c) else $error("ind");
	a_speed_raises: assert property (idle_c && spd_f |=> o_alarm_code == `SFA_CODE_OVERSPEED) else $error("spd");
	a_dev_raises: assert property (idle_c && dev_f && !spd_f |=> o_alarm_code == `SFA_CODE_OVERTRAVEL) else $error("dev");
	a_accum_range: assert property (idle_c && acc_m > 40'h0040000000 |=> o_alarm_code inside {1, 4, 6, 7, 8})
		else $error("acc");
	a_mismatch_raises: assert property (idle_c && i_enc_mismatch |=> !idle_c) else $error("enc");
	a_frame_raises: assert property (idle_c && i_frame_too_long |=> !idle_c) else $error("frm");
	a_brake_raises: assert property (idle_c && i_brake_release_delay_setting > i_brake_delay_max |=> !idle_c)
		else $error("brk");
	a_logic_raises: assert property (idle_c && i_logic_module_err |=> !idle_c) else $error("lgc");
	a_fault_stands: assert property (!idle_c && spd_f |=> $stable(o_alarm_code)) else $error("stand");
	a_code_holds: assert property (!idle_c && !i_alarm_reset && !$past(i_alarm_reset) && !$past(i_alarm_reset, 2)
		|=> $stable(o_alarm_code)) else $error("hold");
	c_crc: cover property (o_alarm_code == `SFA_CODE_CRC);
	c_clear: cover property (!idle_c ##1 idle_c);
	c_refused: cover property (!idle_c && spd_f && i_alarm_reset);
endmodule // sfa_checker

bind sfa_fault_encoder sfa_checker i_sfa_checker (.i_clk(i_clk), .i_rst(i_rst), .i_motor_speed(i_motor_speed),
	.i_overspeed_limit(i_overspeed_limit), .i_deviation_count(i_deviation_count),
	.i_deviation_limit(i_deviation_limit), .i_deviation_accum(i_deviation_accum), .i_enc_mismatch(i_enc_mismatch),
	.i_frame_too_long(i_frame_too_long), .i_brake_release_delay_setting(i_brake_release_delay_setting),
	.i_brake_delay_max(i_brake_delay_max), .i_logic_module_err(i_logic_module_err), .i_alarm_reset(i_alarm_reset),
	.o_alarm_code(o_alarm_code), .o_fault_indicator_output(o_fault_indicator_output));

/* File: sim/sfa_host_model.sv */
// Host model that requests an alarm reset, when asked to, while it sees a code.
module sfa_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_clear_req,
	input  wire logic [5:0] i_alarm_code,
	output logic            o_alarm_reset
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_alarm_reset = 1'b0;
	// The request drops once the code reads zero, so a held code is never re-cleared by accident.
	always @(negedge i_clk) o_alarm_reset <= i_clear_req && (i_alarm_code != 6'h00);
endmodule // sfa_host_model

/* File: sim/sfa_fault_encoder_test.sv */
// Self-checking bench for the servo fault alarm encoder.
`include "sfa_defs.vh"
module sfa_fault_encoder_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] spd, cmd, lim, tol, bdl, bmx, tlv, ttm, tmx;
	logic [31:0] dc, dl;
	logic [39:0] acc;
	logic [16:0] b;
	logic        irq_en, irq, crc_d, crc_f, clr_req, arst, ind;
	logic [5:0]  code;
	int          failures = 0;
	int          total_checks = 0;
	initial forever #50 clk = ~clk;
	sfa_fault_encoder #(.SAT_CYCLES(20), .ILLEG_CYCLES(20), .TMO_CYCLES(10)) i_sfa_fault_encoder (
		.i_clk(clk), .i_rst(rst), .i_motor_speed(spd), .i_speed_command(cmd), .i_overspeed_limit(lim),
		.i_speed_tolerance(tol), .i_deviation_count(dc), .i_deviation_limit(dl), .i_deviation_accum(acc),
		.i_cw_inhibit_ok(b[0]), .i_ccw_inhibit_ok(b[1]), .i_inhibit_check_en(b[2]), .i_phase_u_ok(b[3]),
		.i_phase_v_ok(b[4]), .i_phase_w_ok(b[5]), .i_enc_u(b[6]), .i_enc_v(b[7]), .i_enc_w(b[8]),
		.i_enc_mismatch(b[9]), .i_enc_hiz_seen(b[10]), .i_power_on_check(b[11]), .i_nine_line_mode(b[12]),
		.i_enc_illegal(b[13]), .i_crc_done(crc_d), .i_crc_fail(crc_f), .i_frame_too_long(b[14]),
		.i_loop_irq(irq), .i_brake_release_delay_setting(bdl), .i_brake_delay_max(bmx),
		.i_torque_overload_level_setting(tlv), .i_torque_overload_time_setting(ttm), .i_torque_level_max(tmx),
		.i_sudden_load(b[16]), .i_logic_module_err(b[15]), .i_alarm_reset(arst), .o_alarm_code(code),
		.o_fault_indicator_output(ind));
	sfa_host_model i_sfa_host_model (.i_clk(clk), .i_clear_req(clr_req), .i_alarm_code(code), .o_alarm_reset(arst));
	// Current-loop interrupt every five cycles, well inside the shortened timeout.
	always begin
		repeat (4) @(negedge clk);
		irq = irq_en;
		@(negedge clk);
		irq = 1'b0;
	end
	task tally_and_finish;
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic expect_code(input logic [5:0] c);
		total_checks++;
		if (code !== c || ind !== (c == 6'h00)) begin
			failures++;
			$display("[ERR] %0t code %h ind %b want %h", $time, code, ind, c);
		end
	endtask
	// Legal, fault-free levels on every input.
	task idle;
		{spd, cmd, lim, tol} = {16'h0100, 16'h0100, 16'h0200, 16'h0010};
		{bdl, bmx, tlv, ttm, tmx} = {16'h0000, 16'h0064, 16'h0001, 16'h0001, 16'h0064};
		{dc, dl, acc} = {32'h0000_0000, 32'h0000_03e8, 40'h00_0000_0000};
		b = 17'h0007f;
		{crc_d, crc_f, irq_en} = 3'h1;
	endtask
	task clear;
		idle();
		clr_req <= 1'b1;
		@(negedge clk);
		for (int i = 0; i < 20 && code !== 6'h00; i++) @(negedge clk);
		clr_req <= 1'b0;
		@(negedge clk);
		expect_code(6'h00);
	endtask
	task automatic run(input logic [5:0] c);
		for (int i = 0; i < 40 && code === 6'h00; i++) @(negedge clk);
		expect_code(c);
		clear();
	endtask
	task automatic run_bit(input int n, input logic [5:0] c);
		@(negedge clk) b[n] = ~b[n];
		run(c);
	endtask
	task automatic crc(input logic f);
		@(negedge clk) {crc_d, crc_f} = {1'b1, f};
		@(negedge clk) crc_d = 1'b0;
	endtask
	task automatic quiet(input int n);
		repeat (n) @(negedge clk);
		expect_code(6'h00);
	endtask
	task t_pins;
		run_bit(0, `SFA_CODE_INHIBIT);
		run_bit(4, `SFA_CODE_DISCONN);
		run_bit(6, `SFA_CODE_ENC_CODE);
		run_bit(9, `SFA_CODE_ENC_CODE);
		run_bit(11, `SFA_CODE_ENC_HIZ);
		run_bit(14, `SFA_CODE_FRAME_LEN);
		run_bit(15, `SFA_CODE_LOGIC_ERR);
		run_bit(16, `SFA_CODE_TRQ_OVL);
	endtask
	task t_limits;
		@(negedge clk) spd = 16'h0200;
		quiet(5);
		// With the inhibition check disabled, an ineffective input must not raise a code.
		b[2:0] = 3'h2;
		quiet(8);
		b[2:0] = 3'h7;
		spd = 16'h0201;
		run(`SFA_CODE_OVERSPEED);
		@(negedge clk) dc = 32'hfffffc17;
		run(`SFA_CODE_OVERTRAVEL);
		@(negedge clk) acc = 40'h0040000000;
		quiet(5);
		acc = 40'hffbfffffff;
		run(`SFA_CODE_DEV_RANGE);
		@(negedge clk) bdl = 16'h0065;
		run(`SFA_CODE_BRAKE_DLY);
		@(negedge clk) ttm = 16'h0000;
		run(`SFA_CODE_TRQ_OVL);
	endtask
	task t_timed;
		@(negedge clk) cmd = 16'h0200;
		quiet(15);
		run(`SFA_CODE_SPD_SAT);
		@(negedge clk) b[13:12] = 2'h3;
		quiet(15);
		run(`SFA_CODE_ENC_ILLEG);
		@(negedge clk) irq_en = 1'b0;
		run(`SFA_CODE_LOOP_TMO);
		crc(1);
		crc(1);
		crc(0);
		crc(1);
		crc(1);
		quiet(4);
		crc(1);
		repeat (2) @(negedge clk);
		expect_code(`SFA_CODE_CRC);
		// The failure run only ends with a passing check, so one is sent before clearing.
		crc(0);
		clear();
	endtask
	// A later, higher-priority fault and a reset request while the cause stands must both be refused.
	task t_latch;
		@(negedge clk) b[14] = 1'b1;
		repeat (4) @(negedge clk);
		spd = 16'h0fff;
		clr_req <= 1'b1;
		repeat (8) @(negedge clk);
		expect_code(`SFA_CODE_FRAME_LEN);
		clr_req <= 1'b0;
		run(`SFA_CODE_FRAME_LEN);
	endtask
	initial begin
		idle();
		{irq, clr_req} = 2'h0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		clear();
		t_pins();
		t_limits();
		t_timed();
		t_latch();
		tally_and_finish();
	end
	// Watchdog: about forty times the planned run.
	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end
endmodule // sfa_fault_encoder_test
